//--- logic/sps_pkg.sv
package sps_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] SPS_CTRL_ADDR = 2'h0;  // serial_ctrl_reg
  localparam logic [1:0] SPS_STAT_ADDR = 2'h1;  // serial_status_reg
  localparam logic [1:0] SPS_DATA_ADDR = 2'h2;  // shift_data_port

  // control field positions
  localparam int SPS_CTRL_LSB_FIRST = 7;
  localparam int SPS_CTRL_MASTER    = 6;
  localparam int SPS_CTRL_PHASE     = 5;
  localparam int SPS_CTRL_POLARITY  = 4;
  localparam int SPS_CTRL_SEL_DIS   = 3;

  // status field positions
  localparam int SPS_STAT_ENABLE = 7;
  localparam int SPS_STAT_DONE   = 6;
  localparam int SPS_STAT_FAULT  = 5;
  localparam int SPS_STAT_COLL   = 4;
  localparam int SPS_STAT_OVRN   = 3;

  // reset values
  localparam logic [7:0] SPS_CTRL_RESET = 8'h00;
  localparam logic [7:0] SPS_STAT_RESET = 8'h00;
  localparam logic [7:0] SPS_DATA_RESET = 8'h00;
  localparam logic [7:0] SPS_LATE_BYTE  = 8'h00;

  // timing counts
  localparam int         SPS_BITS_PER_BYTE = 8;
  localparam logic [6:0] SPS_MAX_HALF      = 7'h3f;  // half period minus one at divide by 128

  // control register as a struct
  typedef struct packed {
    logic       lsb_first;
    logic       master_select;
    logic       clock_phase;
    logic       clock_polarity;
    logic       select_pin_disable;
    logic [2:0] rate_select;
  } sps_ctrl_type;

  // serial pins seen by the block
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic sel_n;
  } sps_pins_type;

endpackage : sps_pkg

//--- logic/sps_clk_div.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// master serial clock half-period ticker
// ------------------------------------------------------------------------
module sps_clk_div
  import sps_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       run_i,
  input  wire logic [2:0] rate_i,
  output logic            tick_o
);

  logic [6:0] cnt_q;
  logic [6:0] half_w;

  // half period minus one, in system clocks, for the selected division
  function automatic logic [6:0] sps_half(input logic [2:0] r);
    case (r)
      3'h0:    sps_half = 7'h01;  // /4
      3'h1:    sps_half = 7'h03;  // /8
      3'h2:    sps_half = 7'h07;  // /16
      3'h3:    sps_half = 7'h0f;  // /32
      3'h4:    sps_half = 7'h1f;  // /64
      default: sps_half = SPS_MAX_HALF;  // /128
    endcase
  endfunction : sps_half

  assign half_w = sps_half(rate_i);

  // counter restarts whenever the master is idle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end else if (cnt_q >= half_w) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 7'h01;
      tick_o <= 1'b0;
    end
  end

endmodule : sps_clk_div

//--- logic/sps_port.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module sps_port
  import sps_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  input  wire logic       sel_n_i,
  output logic            irq_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SPS_IDLE, SPS_MRUN, SPS_SRUN} sps_state_type;

  sps_state_type state_q;
  sps_ctrl_type  ctrl_q;
  logic          enable_q, done_q, fault_q, coll_q, ovrn_q;
  logic [7:0]    tx_q, rx_q, rxbuf_q;
  logic          tx_full_q;                  // transmit register holds data
  logic [3:0]    edge_cnt_q;                 // serial clock edges in byte
  logic          sck_int_q, sck_prev_q, sel_prev_q;
  logic          tick_w;
  logic          sck_in_w, selected_w, lead_w, trail_w, sel_fall_w, sample_w, shift_w;
  logic          end_w, wr_data_w, out_bit_w;
  sps_pins_type  pins_w;

  assign pins_w = '{sck: sck_i, mosi: mosi_i, miso: miso_i, sel_n: sel_n_i};

  // ----------------------------------------------------------------------
  // master clock divider
  // ----------------------------------------------------------------------
  sps_clk_div u_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (state_q == SPS_MRUN),
    .rate_i    (ctrl_q.rate_select),
    .tick_o    (tick_w)
  );

  // ----------------------------------------------------------------------
  // slave edge and select decode
  // ----------------------------------------------------------------------
  // selection: forced on when phase 1 and select disabled
  assign selected_w = !pins_w.sel_n
                    || (ctrl_q.clock_phase && ctrl_q.select_pin_disable);
  assign sck_in_w   = pins_w.sck ^ ctrl_q.clock_polarity;
  assign lead_w     = sck_in_w && !sck_prev_q;
  assign trail_w    = !sck_in_w && sck_prev_q;
  assign sel_fall_w = sel_prev_q && pins_w.sel_n == 1'b0;

  // sampling edge: leading for phase 0, trailing for phase 1
  always_comb begin
    sample_w = 1'b0;
    shift_w  = 1'b0;
    if (state_q == SPS_MRUN) begin
      sample_w = tick_w && (sck_int_q == ctrl_q.clock_phase);
      shift_w  = tick_w && (sck_int_q != ctrl_q.clock_phase);
    end else if (state_q == SPS_SRUN && selected_w) begin
      sample_w = ctrl_q.clock_phase ? trail_w : lead_w;
      shift_w  = ctrl_q.clock_phase ? lead_w : trail_w;
    end
  end

  assign end_w     = sample_w && edge_cnt_q == 4'(SPS_BITS_PER_BYTE * 2 - 1)
                   || shift_w && edge_cnt_q == 4'(SPS_BITS_PER_BYTE * 2 - 1);
  assign wr_data_w = wr_i && addr_i == SPS_DATA_ADDR;
  assign out_bit_w = ctrl_q.lsb_first ? tx_q[0] : tx_q[7];

  // ----------------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_in_w;
      sel_prev_q <= pins_w.sel_n;
    end
  end

  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q    <= SPS_IDLE;
      edge_cnt_q <= 4'h0;
      sck_int_q  <= 1'b0;
    end else if (!enable_q) begin
      state_q    <= SPS_IDLE;
      edge_cnt_q <= 4'h0;
      sck_int_q  <= 1'b0;
    end else begin
      case (state_q)
        SPS_IDLE: begin
          edge_cnt_q <= 4'h0;
          sck_int_q  <= 1'b0;
          if (ctrl_q.master_select && wr_data_w && !tx_full_q) begin
            state_q <= SPS_MRUN;
          end else if (!ctrl_q.master_select && selected_w
                       && (ctrl_q.clock_phase || sel_fall_w)) begin
            state_q <= SPS_SRUN;
          end
        end
        SPS_MRUN: begin
          if (!ctrl_q.master_select) begin
            state_q <= SPS_IDLE;
          end else if (tick_w) begin
            sck_int_q  <= !sck_int_q;
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (end_w) begin
              state_q <= SPS_IDLE;
            end
          end
        end
        SPS_SRUN: begin
          if (ctrl_q.master_select
              || (!ctrl_q.clock_phase && pins_w.sel_n)) begin
            state_q <= SPS_IDLE;
          end else if (sample_w || shift_w) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (end_w) begin
              state_q <= ctrl_q.clock_phase ? SPS_SRUN : SPS_IDLE;
              edge_cnt_q <= 4'h0;
            end
          end
        end
        default: state_q <= SPS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // shift registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_q      <= SPS_DATA_RESET;
      tx_full_q <= 1'b0;
      rx_q      <= SPS_DATA_RESET;
    end else begin
      if (wr_data_w && !tx_full_q) begin
        tx_q      <= wdata_i;
        tx_full_q <= 1'b1;
      end else if (shift_w && edge_cnt_q != 4'h0) begin
        tx_q <= ctrl_q.lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end
      if (sample_w) begin
        rx_q <= ctrl_q.lsb_first
              ? {(ctrl_q.master_select ? pins_w.miso : pins_w.mosi), rx_q[7:1]}
              : {rx_q[6:0], (ctrl_q.master_select ? pins_w.miso : pins_w.mosi)};
      end
      if (end_w) begin
        tx_full_q <= 1'b0;
        tx_q      <= SPS_LATE_BYTE;
      end
      if (!enable_q) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q   <= SPS_CTRL_RESET;
      enable_q <= 1'b0;
      done_q   <= 1'b0;
      fault_q  <= 1'b0;
      coll_q   <= 1'b0;
      ovrn_q   <= 1'b0;
      rxbuf_q  <= SPS_DATA_RESET;
    end else begin
      if (wr_i && addr_i == SPS_CTRL_ADDR) begin
        ctrl_q <= wdata_i;
      end
      if (wr_i && addr_i == SPS_STAT_ADDR) begin
        enable_q <= wdata_i[SPS_STAT_ENABLE];
        done_q   <= done_q && wdata_i[SPS_STAT_DONE];
        fault_q  <= fault_q && wdata_i[SPS_STAT_FAULT];
        coll_q   <= coll_q && wdata_i[SPS_STAT_COLL];
        ovrn_q   <= ovrn_q && wdata_i[SPS_STAT_OVRN];
      end
      // hardware sets below win over software clears
      if (wr_data_w && tx_full_q) begin
        coll_q <= 1'b1;
      end
      if (end_w) begin
        if (done_q) begin
          ovrn_q <= 1'b1;
        end else begin
          done_q  <= 1'b1;
          rxbuf_q <= sample_w
                   ? (ctrl_q.lsb_first ? {(ctrl_q.master_select ? pins_w.miso : pins_w.mosi),
                                          rx_q[7:1]}
                                       : {rx_q[6:0], (ctrl_q.master_select ? pins_w.miso
                                                                           : pins_w.mosi)})
                   : rx_q;
        end
      end
      if (enable_q && ctrl_q.master_select && !ctrl_q.select_pin_disable
          && !pins_w.sel_n) begin
        fault_q              <= 1'b1;
        enable_q             <= 1'b0;
        ctrl_q.master_select <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        SPS_CTRL_ADDR: rdata_o <= ctrl_q;
        SPS_STAT_ADDR: rdata_o <= {enable_q, done_q, fault_q, coll_q, ovrn_q, 3'h0};
        SPS_DATA_ADDR: rdata_o <= rxbuf_q;
        default:       rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sck_o     <= 1'b0;
      sck_oe_o  <= 1'b0;
      mosi_o    <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      sck_oe_o  <= enable_q && ctrl_q.master_select;
      sck_o     <= (state_q == SPS_MRUN ? sck_int_q : 1'b0) ^ ctrl_q.clock_polarity;
      mosi_oe_o <= enable_q && ctrl_q.master_select;
      mosi_o    <= out_bit_w;
      miso_oe_o <= enable_q && !ctrl_q.master_select && selected_w;
      miso_o    <= out_bit_w;
      irq_o     <= done_q || (fault_q && !ctrl_q.select_pin_disable);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  no_fault_dis_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_q.select_pin_disable && !fault_q |=> !fault_q)
    else $error("fault set with select disabled");
  fault_drop_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    enable_q && ctrl_q.master_select && !ctrl_q.select_pin_disable && !sel_n_i
    |=> fault_q && !enable_q && !ctrl_q.master_select)
    else $error("mode fault not taken");
  coll_set_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_data_w && tx_full_q |=> coll_q && ($stable(tx_q) || $past(shift_w || end_w)))
    else $error("collision not flagged");
  ovrn_set_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    end_w && done_q |=> ovrn_q && $stable(rxbuf_q))
    else $error("overrun not flagged");
  miso_float_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sel_n_i && !(ctrl_q.clock_phase && ctrl_q.select_pin_disable) |=> !miso_oe_o)
    else $error("unselected slave drives data");
  master_start_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == SPS_IDLE && enable_q && ctrl_q.master_select && wr_data_w && !tx_full_q
    && !(!ctrl_q.select_pin_disable && !sel_n_i) |=> state_q == SPS_MRUN)
    else $error("master write did not start");
  idle_clock_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == SPS_IDLE ##1 state_q == SPS_IDLE |-> sck_o == $past(ctrl_q.clock_polarity))
    else $error("idle clock level wrong");
  disabled_idle_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !enable_q |=> state_q == SPS_IDLE)
    else $error("disabled port active");

  // last of the sixteen master clock edges
  sequence sps_last_edge_s;
    state_q == SPS_MRUN && enable_q && ctrl_q.master_select && end_w;
  endsequence

  // master byte ends after sixteen edges and flags it
  master_end_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sps_last_edge_s |=> state_q == SPS_IDLE && (done_q || ovrn_q))
    else $error("master byte did not end");

  // finished byte leaves the zero byte for a late load
  late_zero_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    end_w |=> tx_q == SPS_LATE_BYTE && !tx_full_q)
    else $error("late byte not zero");

  // slave byte sets the done flag
  slave_done_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == SPS_SRUN && end_w && !done_q |=> done_q)
    else $error("slave byte not flagged");

endmodule : sps_port

//--- test/sps_far_slave.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// far side slave, clock phase 0, polarity 0
// ----------------------------------------------------------------------
module sps_far_slave (
  input  wire logic       clk_i,
  input  wire logic       sel_n_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o
);
  logic [7:0] sh_q;
  logic       sck_q;
  logic       sel_q;
  logic       last_q;
  logic       bit_w;
  logic       fall_w;

  // a falling clock shows the next bit at once, as a real slave does
  assign fall_w = !sel_n_i && sck_q && !sck_i;
  assign bit_w  = fall_w ? (lsb_i ? sh_q[1] : sh_q[6]) : (lsb_i ? sh_q[0] : sh_q[7]);
  // released line shows the inverse of its last level
  assign miso_o = sel_n_i ? ~last_q : bit_w;

  // load on select fall, sample on rising, shift on falling
  always @(posedge clk_i) begin
    sck_q <= sck_i;
    sel_q <= sel_n_i;
    if (!sel_n_i) last_q <= bit_w;
    if (sel_q && !sel_n_i) sh_q <= tx_i;
    else if (!sel_n_i && sck_i && !sck_q)
      rx_o <= lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
    else if (!sel_n_i && !sck_i && sck_q)
      sh_q <= lsb_i ? (sh_q >> 1) : (sh_q << 1);
  end
endmodule : sps_far_slave

//--- test/sps_port_bench.sv
`timescale 1ns/1ps
module sps_port_bench
  import sps_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [7:0] rdata_o;
  logic       sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, irq_o;
  logic       b_sck = 1'b0;
  logic       b_mosi = 1'b0;
  logic       dsel_n = 1'b1;
  logic       psel_n = 1'b1;
  logic       pl = 1'b0;
  logic [7:0] pt = 8'h00;
  logic [7:0] prx;
  logic       pmiso;
  logic       sck_p = 1'b0;
  logic [7:0] v;
  int         errors = 0;
  int         check_count = 0;
  int         toggles = 0;
  int         cyc = 0;
  int         t1 = 0;
  int         t2 = 0;

  always #12.5 clk_i = ~clk_i;

  sps_port DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata_o),
    .sck_i(sck_oe_o ? sck_o : b_sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_i(mosi_oe_o ? mosi_o : b_mosi), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
    .miso_i(pmiso), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .sel_n_i(dsel_n), .irq_o(irq_o)
  );

  sps_far_slave far (
    .clk_i(clk_i), .sel_n_i(psel_n), .sck_i(sck_o), .mosi_i(mosi_o),
    .lsb_i(pl), .tx_i(pt), .miso_o(pmiso), .rx_o(prx)
  );

  // counts serial clock toggles and the moments of the first two
  always @(posedge clk_i) begin
    cyc++;
    if (sck_o !== sck_p) begin
      if (toggles == 0) t1 = cyc;
      if (toggles == 1) t2 = cyc;
      toggles++;
    end
    sck_p = sck_o;
  end

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // master transfer against the far slave
  task automatic mx(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] ptx,
                    input logic coll);
    int n;
    wr(SPS_CTRL_ADDR, c);
    pl <= c[7];
    pt <= ptx;
    psel_n <= 1'b0;
    toggles = 0;
    wr(SPS_DATA_ADDR, tx);
    if (coll) wr(SPS_DATA_ADDR, 8'hff);
    n = 0;
    while (toggles < 16 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (140) @(posedge clk_i);
    psel_n <= 1'b1;
    chk(8'(toggles), 8'h10);
    chk(prx, tx);
  endtask : mx

  // bench as master, msb first; phase 1 moves data on the rising edge
  task automatic sx(input logic ph, input logic [7:0] mo, output logic [7:0] so);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) b_mosi <= mo[i];
      repeat (4) @(posedge clk_i);
      so[i] = miso_o;
      b_sck <= 1'b1;
      if (ph) b_mosi <= mo[i];
      repeat (4) @(posedge clk_i);
      b_sck <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask : sx

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), v);
      chk(v, 8'h00);
    end
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(SPS_STAT_ADDR, 8'h80);
      mx(8'h40 | 8'(c) | (c == 2 ? 8'h80 : 8'h00), 8'h96 ^ 8'(c), 8'h3c + 8'(c), 1'b0);
      chk(8'(t2 - t1), 8'((4 << (c > 5 ? 5 : c)) / 2));
      rd(SPS_DATA_ADDR, v);
      chk(v, 8'h3c + 8'(c));
      chk({7'h0, irq_o}, 8'h01);
    end
    $display("test rates done");
    mx(8'h47, 8'h81, 8'h24, 1'b1);
    rd(SPS_STAT_ADDR, v);
    chk(v, 8'hd8);
    rd(SPS_DATA_ADDR, v);
    chk(v, 8'h43);
    $display("test collision done");
    wr(SPS_CTRL_ADDR, 8'h40);
    wr(SPS_STAT_ADDR, 8'h80);
    dsel_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(SPS_STAT_ADDR, v);
    chk(v, 8'h20);
    chk({7'h0, irq_o}, 8'h01);
    rd(SPS_CTRL_ADDR, v);
    chk(v, 8'h00);
    wr(SPS_CTRL_ADDR, 8'h48);
    wr(SPS_STAT_ADDR, 8'h80);
    repeat (4) @(posedge clk_i);
    rd(SPS_STAT_ADDR, v);
    chk(v, 8'h80);
    dsel_n <= 1'b1;
    $display("test fault done");
    wr(SPS_CTRL_ADDR, 8'h50);
    repeat (4) @(posedge clk_i);
    chk({6'h0, sck_oe_o, sck_o}, 8'h03);
    wr(SPS_STAT_ADDR, 8'h00);
    wr(SPS_CTRL_ADDR, 8'h40);
    repeat (4) @(posedge clk_i);
    toggles = 0;
    wr(SPS_DATA_ADDR, 8'h55);
    repeat (64) @(posedge clk_i);
    chk(8'(toggles), 8'h00);
    $display("test idle done");
    wr(SPS_CTRL_ADDR, 8'h00);
    wr(SPS_STAT_ADDR, 8'h80);
    wr(SPS_DATA_ADDR, 8'ha5);
    sx(1'b0, 8'h77, v);
    chk({6'h0, miso_oe_o, sck_oe_o}, 8'h00);
    rd(SPS_STAT_ADDR, v);
    chk(v, 8'h80);
    dsel_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    sx(1'b0, 8'h3c, v);
    dsel_n <= 1'b1;
    chk(v, 8'ha5);
    rd(SPS_STAT_ADDR, v);
    chk(v, 8'hc0);
    rd(SPS_DATA_ADDR, v);
    chk(v, 8'h3c);
    wr(SPS_STAT_ADDR, 8'h80);
    dsel_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    sx(1'b0, 8'h11, v);
    dsel_n <= 1'b1;
    chk(v, 8'h00);
    wr(SPS_CTRL_ADDR, 8'h28);
    wr(SPS_STAT_ADDR, 8'h80);
    sx(1'b1, 8'h5a, v);
    rd(SPS_DATA_ADDR, v);
    chk(v, 8'h5a);
    $display("test slave done");
    conclude();
  end
endmodule : sps_port_bench
